// *** common/pcc_pkg.sv ***
package pcc_pkg;
  typedef enum logic [0:0] {
    PCC_EE_IDLE = 1'b0,
    PCC_EE_BUSY = 1'b1
  } pcc_ee_state_t;
endpackage : pcc_pkg

// *** common/pcc_regs.svh ***
`ifndef PCC_REGS_SVH
`define PCC_REGS_SVH
// Overview of operation
// - card information store sits in attribute space 000h up to 3FFh.
// - only even bytes exist; an odd address reaches the even byte below it.
// - store answers only while the function select pin is low.
// - store writes refused unless unlocked; unlock clears on card reset.
// - host I/O cycles ignored until the option register is configured.
// - option register decodes at 400h plus 20h times the function number.
// - soft reset bit 7 resets selected registers and stays set until cleared.
// - store writes accepted only with unlock bit 5 high and index bits 2:0 zero.
// - index field is bits 4:0; bit 0 enables the I/O target.
// - index bit 1 clear: decode by card enable and A2:0; set: base registers qualify.
// - index bit 2 gates the interrupt request to the host.
// - memory-mapped mode: uart registers also in common memory from 0h.
// - configuration registers also in common memory from 400h, same spacing.
// - activity output is driven low during each strobe accessing a uart register.
// - function select pin chooses the per-function configuration offset.
`define PCC_EE_TOP 11'h3ff
`define PCC_COR_OFS 11'h400
`define PCC_FN_STRIDE 11'h020
`define PCC_BASE_LO_OFS 11'h40a
`define PCC_BASE_HI_OFS 11'h40c
`define PCC_CM_CCR_OFS 11'h400
`define PCC_COR_SRST 7
`define PCC_COR_EEPROM_WRITE_UNLOCK 5
`define PCC_COR_TGT 0
`define PCC_COR_BASE 1
`define PCC_COR_IRQ 2
`define PCC_COR_WMASK 8'hbf
`define PCC_RST_VAL 8'h00
`define PCC_CLK_MHZ 25
`define PCC_EE_PROG_US 1000
`endif

// *** design/pcc_config_space.sv ***
`timescale 1ns/1ns
`include "pcc_regs.svh"
module pcc_config_space #(
  parameter int EE_PROG_CYC = `PCC_EE_PROG_US * `PCC_CLK_MHZ,
  parameter bit MEM_MAP_EN = 1'b1
) (
  // clock and reset
  input wire logic REF_CLK,
  input wire logic RST_N,
  // host bus pins
  input wire logic [10:0] HOST_A,
  input wire logic [7:0] HOST_D_IN,
  output logic [7:0] HOST_D_OUT,
  output logic HOST_D_OE,
  input wire logic CE1_N,
  input wire logic OE_N,
  input wire logic WE_N,
  input wire logic IORD_N,
  input wire logic IOWR_N,
  input wire logic REG_N,
  input wire logic FUNCTION_SELECT_PIN,
  output logic HOST_IRQ_N,
  // activity output, open drain
  output logic ACTIVITY_LED_N_OUT,
  output logic ACTIVITY_LED_N_OE,
  // uart register port
  output logic [2:0] UART_ADDR,
  output logic [7:0] UART_WDATA,
  output logic UART_RD_STB,
  output logic UART_WR_STB,
  input wire logic [7:0] UART_RDATA,
  input wire logic UART_IRQ,
  // configuration state
  output logic SOFT_RESET
);
  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers: {fn, reg, iowr, iord, we, oe, ce, d, a}
  localparam int SW = 26;
  localparam logic [15:0] PROG_CYC = 16'(EE_PROG_CYC);
  logic [SW-1:0] pins, sync1_ff, sync2_ff, prev_ff;
  assign pins = {FUNCTION_SELECT_PIN, REG_N, IOWR_N, IORD_N, WE_N, OE_N, CE1_N, HOST_D_IN, HOST_A};
  // first stage feeds only the second; prev_ff gives edges on clean values
  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      // idle levels: strobes high, function pin low, so no false edge after reset
      sync1_ff <= {1'b0, 6'h3f, 19'h00000};
      sync2_ff <= {1'b0, 6'h3f, 19'h00000};
      prev_ff <= {1'b0, 6'h3f, 19'h00000};
    end else begin
      sync1_ff <= pins;
      sync2_ff <= sync1_ff;
      prev_ff <= sync2_ff;
    end
  end
  logic [10:0] a, pa;
  logic [7:0] pd;
  logic ce, oe, we, iord, iowr, attr, fn, pce, pwe, piowr, pattr, pfn;
  assign a = sync2_ff[10:0];
  assign ce = ~sync2_ff[19];
  assign oe = ~sync2_ff[20];
  assign we = ~sync2_ff[21];
  assign iord = ~sync2_ff[22];
  assign iowr = ~sync2_ff[23];
  assign attr = ~sync2_ff[24];
  assign fn = sync2_ff[25];
  assign pa = prev_ff[10:0];
  assign pd = prev_ff[18:11];
  assign pce = ~prev_ff[19];
  assign pwe = ~prev_ff[21];
  assign piowr = ~prev_ff[23];
  assign pattr = ~prev_ff[24];
  assign pfn = prev_ff[25];

  ////////////////////////////////////////////////////////////////////////////
  // address decode helpers
  function automatic logic [10:0] ccr_ofs(input logic [10:0] base, input logic f);
    ccr_ofs = base + (f ? `PCC_FN_STRIDE : 11'h000);
  endfunction : ccr_ofs
  logic [7:0] cor_ff, nxt_cor, base_lo_ff, nxt_base_lo, base_hi_ff, nxt_base_hi;
  logic [7:0] io_base;
  logic ee_unlocked;
  assign io_base = {base_lo_ff[7:3], base_hi_ff[2:0]};
  assign ee_unlocked = cor_ff[`PCC_COR_EEPROM_WRITE_UNLOCK] & (cor_ff[2:0] == 3'h0);
  // config regs reachable in attribute space, or common space when mem mapped
  function automatic logic cfg_space(input logic is_attr);
    cfg_space = is_attr | MEM_MAP_EN;
  endfunction : cfg_space
  // uart hit for an I/O cycle or a memory-mapped common cycle
  function automatic logic uart_hit(input logic [10:0] ad, input logic is_io, input logic is_attr);
    logic base_ok;
    base_ok = !cor_ff[`PCC_COR_BASE] || (ad[10:3] == io_base);
    if (is_io)
      uart_hit = is_attr && cor_ff[`PCC_COR_TGT] && base_ok;
    else
      uart_hit = MEM_MAP_EN && !is_attr && (ad[10:3] == 8'h00);
  endfunction : uart_hit

  ////////////////////////////////////////////////////////////////////////////
  // store: even bytes only, address bit 0 ignored
  logic [7:0] ee_mem [0:511];
  logic [8:0] ee_idx, pee_idx;
  logic ee_hit, pee_wr;
  assign ee_idx = a[9:1];
  assign pee_idx = pa[9:1];
  assign ee_hit = attr && !fn && (a <= `PCC_EE_TOP);
  assign pee_wr = pce && pwe && !we && pattr && !pfn && (pa <= `PCC_EE_TOP);
  pcc_pkg::pcc_ee_state_t ee_st_ff, nxt_ee_st;
  logic [15:0] ee_cnt_ff, nxt_ee_cnt;
  logic [8:0] ee_tidx_ff, nxt_ee_tidx;
  logic [7:0] ee_tdat_ff, nxt_ee_tdat;
  logic ee_commit;
  // an unlocked write while idle starts a program cycle; reads of it poll until the byte lands
  always_comb begin
    nxt_ee_st = ee_st_ff;
    nxt_ee_cnt = ee_cnt_ff;
    nxt_ee_tidx = ee_tidx_ff;
    nxt_ee_tdat = ee_tdat_ff;
    ee_commit = 1'b0;
    case (ee_st_ff)
      pcc_pkg::PCC_EE_IDLE: begin
        if (pee_wr && ee_unlocked) begin
          nxt_ee_st = pcc_pkg::PCC_EE_BUSY;
          nxt_ee_cnt = PROG_CYC;
          nxt_ee_tidx = pee_idx;
          nxt_ee_tdat = pd;
        end
      end
      pcc_pkg::PCC_EE_BUSY: begin
        if (ee_cnt_ff <= 16'h0001) begin
          nxt_ee_st = pcc_pkg::PCC_EE_IDLE;
          nxt_ee_cnt = 16'h0000;
          ee_commit = 1'b1;
        end else begin
          nxt_ee_cnt = ee_cnt_ff - 16'h0001;
        end
      end
      default: nxt_ee_st = pcc_pkg::PCC_EE_IDLE;
    endcase
  end
  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      ee_st_ff <= pcc_pkg::PCC_EE_IDLE;
      ee_cnt_ff <= 16'h0000;
      ee_tidx_ff <= 9'h000;
      ee_tdat_ff <= 8'h00;
    end else begin
      ee_st_ff <= nxt_ee_st;
      ee_cnt_ff <= nxt_ee_cnt;
      ee_tidx_ff <= nxt_ee_tidx;
      ee_tdat_ff <= nxt_ee_tdat;
    end
  end
  // nonvolatile array, no reset by nature
  always_ff @(posedge REF_CLK) begin
    if (ee_commit)
      ee_mem[ee_tidx_ff] <= ee_tdat_ff;
  end

  ////////////////////////////////////////////////////////////////////////////
  // configuration registers; writes land at the end of the write strobe
  logic pcfg_wr;
  assign pcfg_wr = pce && pwe && !we && cfg_space(pattr);
  always_comb begin
    nxt_cor = cor_ff;
    nxt_base_lo = base_lo_ff;
    nxt_base_hi = base_hi_ff;
    if (pcfg_wr && pa == ccr_ofs(`PCC_COR_OFS, pfn))
      nxt_cor = pd & `PCC_COR_WMASK;
    if (pcfg_wr && pa == ccr_ofs(`PCC_BASE_LO_OFS, pfn))
      nxt_base_lo = pd;
    if (pcfg_wr && pa == ccr_ofs(`PCC_BASE_HI_OFS, pfn))
      nxt_base_hi = pd;
    // soft reset holds the other fields cleared while it stays set
    if (nxt_cor[`PCC_COR_SRST]) begin
      nxt_cor = 8'h80;
      nxt_base_lo = `PCC_RST_VAL;
      nxt_base_hi = `PCC_RST_VAL;
    end
  end
  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      cor_ff <= `PCC_RST_VAL;
      base_lo_ff <= `PCC_RST_VAL;
      base_hi_ff <= `PCC_RST_VAL;
    end else begin
      cor_ff <= nxt_cor;
      base_lo_ff <= nxt_base_lo;
      base_hi_ff <= nxt_base_hi;
    end
  end
  assign SOFT_RESET = cor_ff[`PCC_COR_SRST];

  ////////////////////////////////////////////////////////////////////////////
  // uart access, read data and activity indicator
  logic io_rd_hit, io_wr_hit, mm_rd_hit, mm_wr_hit, rd_act, uart_act;
  assign io_rd_hit = ce && iord && uart_hit(a, 1'b1, attr);
  assign io_wr_hit = ce && iowr && uart_hit(a, 1'b1, attr);
  assign mm_rd_hit = ce && oe && uart_hit(a, 1'b0, attr);
  assign mm_wr_hit = ce && we && uart_hit(a, 1'b0, attr);
  assign uart_act = io_rd_hit || io_wr_hit || mm_rd_hit || mm_wr_hit;
  // drive only when something answers; function 1 leaves the store to function 0
  assign rd_act = io_rd_hit || mm_rd_hit ||
                  (ce && oe && (ee_hit || (cfg_space(attr) && a > `PCC_EE_TOP)));
  logic [7:0] rdat, dout_ff, uwd_ff;
  logic doe_ff, led_ff, urd_ff, uwr_ff, uact_ff, irq_n_ff;
  logic [2:0] uad_ff;
  always_comb begin
    rdat = 8'h00;
    if (io_rd_hit || mm_rd_hit)
      rdat = UART_RDATA;
    else if (ee_hit && ee_st_ff == pcc_pkg::PCC_EE_BUSY && ee_idx == ee_tidx_ff)
      rdat = ~ee_tdat_ff; // poll mismatch until programming ends
    else if (ee_hit)
      rdat = ee_mem[ee_idx];
    else if (cfg_space(attr) && a == ccr_ofs(`PCC_COR_OFS, fn))
      rdat = cor_ff;
    else if (cfg_space(attr) && a == ccr_ofs(`PCC_BASE_LO_OFS, fn))
      rdat = base_lo_ff;
    else if (cfg_space(attr) && a == ccr_ofs(`PCC_BASE_HI_OFS, fn))
      rdat = base_hi_ff;
  end
  // outputs registered; strobes are one-cycle pulses on entry / exit
  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      dout_ff <= 8'h00;
      doe_ff <= 1'b0;
      led_ff <= 1'b0;
      uad_ff <= 3'h0;
      uwd_ff <= 8'h00;
      urd_ff <= 1'b0;
      uwr_ff <= 1'b0;
      uact_ff <= 1'b0;
      irq_n_ff <= 1'b1;
    end else begin
      dout_ff <= rdat;
      doe_ff <= rd_act;
      led_ff <= uart_act;
      uact_ff <= uart_act;
      if (uart_act)
        uad_ff <= a[2:0];
      urd_ff <= (io_rd_hit || mm_rd_hit) && !uact_ff;
      uwr_ff <= uact_ff && !uart_act && (piowr || pwe);
      if (uact_ff && !uart_act)
        uwd_ff <= pd;
      irq_n_ff <= !(UART_IRQ && cor_ff[`PCC_COR_IRQ]);
    end
  end
  assign HOST_D_OUT = dout_ff;
  assign HOST_D_OE = doe_ff;
  assign ACTIVITY_LED_N_OUT = 1'b0;
  assign ACTIVITY_LED_N_OE = led_ff;
  assign UART_ADDR = uad_ff;
  assign UART_WDATA = uwd_ff;
  assign UART_RD_STB = urd_ff;
  assign UART_WR_STB = uwr_ff;
  assign HOST_IRQ_N = irq_n_ff;

  ////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (!RST_N);
  AST_EE_LOCKED: assert property (pee_wr && !ee_unlocked && ee_st_ff == pcc_pkg::PCC_EE_IDLE |=>
    ee_st_ff == pcc_pkg::PCC_EE_IDLE) else $error("store write taken while locked");
  AST_EE_FN1: assert property (fn && ce && oe && !iord && attr && a <= `PCC_EE_TOP |=> !HOST_D_OE)
    else $error("store answered with function 1");
  AST_EE_PROG: assert property ($rose(ee_st_ff == pcc_pkg::PCC_EE_BUSY) |-> $past(ee_unlocked))
    else $error("program cycle without unlock");
  AST_IO_GATE: assert property (!cor_ff[`PCC_COR_TGT] && attr && ce && (iord || iowr) |=>
    !UART_RD_STB && !ACTIVITY_LED_N_OE)
    else $error("I/O hit before target enable");
  AST_LED: assert property (uart_act |=> ACTIVITY_LED_N_OE && !ACTIVITY_LED_N_OUT)
    else $error("activity output idle during uart access");
  AST_BIT6: assert property (cor_ff[6] == 1'b0) else $error("option bit 6 set");
  AST_SRST: assert property (cor_ff[`PCC_COR_SRST] |-> cor_ff[5:0] == 6'h00 && io_base == 8'h00)
    else $error("soft reset did not clear fields");
  AST_IRQ: assert property (!cor_ff[`PCC_COR_IRQ] |=> HOST_IRQ_N)
    else $error("interrupt driven while disabled");
  AST_BASE: assert property (cor_ff[`PCC_COR_BASE] && attr && a[10:3] != io_base |-> !io_rd_hit)
    else $error("base decode ignored");
  COV_EE_WRITE: cover property (ee_commit);
  COV_IO_READ: cover property (UART_RD_STB && cor_ff[`PCC_COR_BASE]);
  COV_MM_WRITE: cover property (mm_wr_hit ##1 !mm_wr_hit);
endmodule : pcc_config_space

// *** dv/pcc_host_model.sv ***
`timescale 1ns/1ns
module pcc_host_model #(
  // about 18 ms of polls at eleven cycles each
  parameter int POLL_MAX = 41666
) (
  // clock
  input wire logic clk,
  // card answer
  input wire logic [7:0] d_out,
  input wire logic d_oe,
  // host pins
  output logic [10:0] a,
  output logic [7:0] d,
  output logic ce1_n,
  output logic oe_n,
  output logic we_n,
  output logic iord_n,
  output logic iowr_n,
  output logic reg_n
);
  // idle bus, every strobe high
  initial begin
    a = 11'h000;
    d = 8'h00;
    {ce1_n, oe_n, we_n, iord_n, iowr_n, reg_n} = 6'h3f;
  end
  ////////////////////////////////////////////////////////////////
  // one strobe: sp 0 attribute, 1 io, 2 common; io strobes idle outside io cycles
  task automatic acc(input logic [1:0] sp, input logic wr, input logic [10:0] adr, input logic [7:0] dat,
                     output logic [7:0] q, output logic hit);
    @(posedge clk);
    a <= adr;
    d <= wr ? dat : ~d; // released lines show the inverse, not a stale value
    reg_n <= (sp == 2'h2);
    ce1_n <= 1'b0;
    if (sp == 2'h1) begin
      iord_n <= wr;
      iowr_n <= !wr;
    end else begin
      oe_n <= wr;
      we_n <= !wr;
    end
    repeat (5) @(posedge clk);
    q = d_out;
    hit = d_oe;
    {ce1_n, oe_n, we_n, iord_n, iowr_n} <= 5'h1f;
    d <= ~d;
    repeat (5) @(posedge clk);
  endtask : acc
  ////////////////////////////////////////////////////////////////
  // write, then re-read until it matches or the time limit is spent
  task automatic ee_prog(input logic [10:0] adr, input logic [7:0] dat, output logic ok);
    logic [7:0] q;
    logic h;
    acc(2'h0, 1'b1, adr, dat, q, h);
    ok = 1'b0;
    for (int n = 0; n < POLL_MAX && !ok; n++) begin
      acc(2'h0, 1'b0, adr, 8'h00, q, h);
      ok = (q === dat);
    end
  endtask : ee_prog
endmodule : pcc_host_model

// *** dv/tb_top.sv ***
`timescale 1ns/1ns
module tb_top;
  logic clk, rst_n, d_oe, ce1_n, oe_n, we_n, iord_n, iowr_n, reg_n, irq_n, led_oe, rd_stb, soft_rst;
  logic [10:0] a;
  logic [7:0] d, d_out, wdata;
  logic [2:0] uaddr;
  logic fsel = 1'b0;
  logic uirq = 1'b0;
  logic [7:0] urdata = 8'h5a;
  int fails = 0;
  int tests_run = 0;
  int n_rd = 0;
  int n_wr = 0;
  logic led_out, wr_stb;
  logic led_seen = 1'b0;
  // short programming time keeps the poll loop brief
  pcc_config_space #(.EE_PROG_CYC(20)) dut (.REF_CLK(clk), .RST_N(rst_n), .HOST_A(a), .HOST_D_IN(d),
    .HOST_D_OUT(d_out), .HOST_D_OE(d_oe), .CE1_N(ce1_n), .OE_N(oe_n), .WE_N(we_n), .IORD_N(iord_n),
    .IOWR_N(iowr_n), .REG_N(reg_n), .FUNCTION_SELECT_PIN(fsel), .HOST_IRQ_N(irq_n), .ACTIVITY_LED_N_OUT(led_out),
    .ACTIVITY_LED_N_OE(led_oe), .UART_ADDR(uaddr), .UART_WDATA(wdata), .UART_RD_STB(rd_stb),
    .UART_WR_STB(wr_stb), .UART_RDATA(urdata), .UART_IRQ(uirq), .SOFT_RESET(soft_rst));
  // poll bound shrunk to match the short programming time
  pcc_host_model #(.POLL_MAX(8)) host (.clk(clk), .d_out(d_out), .d_oe(d_oe), .a(a), .d(d), .ce1_n(ce1_n),
    .oe_n(oe_n), .we_n(we_n), .iord_n(iord_n), .iowr_n(iowr_n), .reg_n(reg_n));
  // clock and uart strobe watchers
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  always @(posedge clk) begin
    if (rd_stb === 1'b1) n_rd <= n_rd + 1;
    if (wr_stb === 1'b1) n_wr <= n_wr + 1;
    if (led_oe === 1'b1 && led_out === 1'b0) led_seen <= 1'b1;
  end
  ////////////////////////////////////////////////////////////////
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      fails++;
      $display("ERROR at %0t ns: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [1:0] sp, input logic [10:0] ad, input logic [7:0] dt);
    logic [7:0] q;
    logic h;
    host.acc(sp, 1'b1, ad, dt, q, h);
  endtask : wr
  // read expecting a hit (hx 1) or no answer (hx 0)
  task automatic rd(input logic [1:0] sp, input logic [10:0] ad, input logic [7:0] exp, input logic hx);
    logic [7:0] q;
    logic h;
    host.acc(sp, 1'b0, ad, 8'h00, q, h);
    chk({7'h00, h}, {7'h00, hx});
    if (hx) chk(q, exp);
  endtask : rd
  task automatic results();
    $display("comparisons %0d, mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : results
  ////////////////////////////////////////////////////////////////
  task automatic t_cor();
    rd(2'h0, 11'h400, 8'h00, 1'b1);
    wr(2'h0, 11'h400, 8'hff);
    rd(2'h0, 11'h400, 8'h80, 1'b1);
    chk({7'h00, soft_rst}, 8'h01);
    wr(2'h0, 11'h400, 8'h00);
    wr(2'h0, 11'h400, 8'h5f);
    rd(2'h0, 11'h400, 8'h1f, 1'b1);
    chk({7'h00, led_seen}, 8'h00);
  endtask : t_cor
  task automatic t_io();
    int k;
    wr(2'h0, 11'h400, 8'h00);
    k = n_rd;
    rd(2'h1, 11'h003, 8'h00, 1'b0);
    chk(8'(n_rd - k), 8'h00);
    wr(2'h0, 11'h400, 8'h05);
    rd(2'h1, 11'h003, 8'h5a, 1'b1);
    chk(8'(n_rd - k), 8'h01);
    chk({5'h00, uaddr}, 8'h03);
    chk({7'h00, led_seen}, 8'h01);
    wr(2'h1, 11'h006, 8'h3c);
    chk(wdata, 8'h3c);
    chk(8'(n_wr), 8'h01);
    chk({5'h00, uaddr}, 8'h06);
    uirq <= 1'b1;
    repeat (4) @(posedge clk);
    chk({7'h00, irq_n}, 8'h00);
    wr(2'h0, 11'h400, 8'h01);
    chk({7'h00, irq_n}, 8'h01);
    uirq <= 1'b0;
  endtask : t_io
  task automatic t_mem_base();
    wr(2'h2, 11'h400, 8'h05);
    rd(2'h0, 11'h400, 8'h05, 1'b1);
    rd(2'h2, 11'h005, 8'h5a, 1'b1);
    wr(2'h2, 11'h001, 8'h77);
    chk(wdata, 8'h77);
    chk({5'h00, uaddr}, 8'h01);
    chk(8'(n_wr), 8'h02);
    wr(2'h0, 11'h40a, 8'h28);
    wr(2'h0, 11'h40c, 8'h01);
    wr(2'h0, 11'h400, 8'h07);
    rd(2'h1, 11'h14a, 8'h5a, 1'b1);
    chk({5'h00, uaddr}, 8'h02);
    rd(2'h1, 11'h002, 8'h00, 1'b0);
  endtask : t_mem_base
  task automatic t_fn_ee();
    logic ok;
    fsel <= 1'b1;
    wr(2'h0, 11'h420, 8'h09);
    rd(2'h0, 11'h420, 8'h09, 1'b1);
    rd(2'h0, 11'h010, 8'h00, 1'b0);
    fsel <= 1'b0;
    wr(2'h0, 11'h400, 8'h20);
    host.ee_prog(11'h3fe, 8'ha5, ok);
    chk({7'h00, ok}, 8'h01);
    if (!ok) results();
    rd(2'h0, 11'h3ff, 8'ha5, 1'b1);
    wr(2'h0, 11'h400, 8'h25);
    wr(2'h0, 11'h3fe, 8'h11);
    rd(2'h0, 11'h3fe, 8'ha5, 1'b1);
    wr(2'h0, 11'h400, 8'h20);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    rd(2'h0, 11'h400, 8'h00, 1'b1);
    wr(2'h0, 11'h3fe, 8'h11);
    rd(2'h0, 11'h3fe, 8'ha5, 1'b1);
  endtask : t_fn_ee
  ////////////////////////////////////////////////////////////////
  // reset held for twenty cycles, then each scenario in turn
  initial begin
    rst_n = 1'b0;
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    t_cor();
    t_io();
    t_mem_base();
    t_fn_ee();
    results();
  end
endmodule : tb_top
